//--- t1_framer_link_irq_regs.sv
// Framer and data link interrupt enable and status registers on AHB-Lite
//
// Overview of operation
// - CRC-6 error raises interrupt when enabled
// - Framing bit error raises interrupt when enabled
// - Framing bit errors independent of out-of-frame
// - Read-only bit shows last received message kind
// - Transmit start event sets its flag
// - Receive start event sets its flag
// - Transmit end event sets its flag
// - Link flags clear when status is read
// - Link events interrupt only when enabled
`timescale 1ns/100ps
`include "link_irq_defines.svh"
module t1_framer_link_irq_regs
   import link_irq_pkg::*;
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic      [31:0]  hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire link_events_s events,
   input  wire logic         out_of_frame,
   input  wire logic         rx_message_kind,
   input  wire logic         rx_message_valid,
   output logic              irq
);

   // -----------------------------------------------------------------
   // Bus address phase capture
   // -----------------------------------------------------------------
   bus_phase_e            phase_r;
   bus_phase_e            phase_nxt;
   logic [`ADDR_W-1:0]    addr_r;
   logic [`ADDR_W-1:0]    addr_nxt;

   // Exact address match only; hsize is not checked, so any transfer size reaches the registers
   function automatic logic is_reg(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] r);
      is_reg = (a == r);
   endfunction

   logic take;
   assign take = hsel && hready && htrans[1];

   // Address phase is registered; data phase follows with zero wait
   always_comb begin
      phase_nxt = PH_IDLE;
      addr_nxt  = addr_r;
      if (take) begin
         addr_nxt  = haddr[`ADDR_W-1:0];
         phase_nxt = hwrite ? PH_WRITE : PH_READ;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r <= PH_IDLE;
         addr_r  <= '0;
      end else begin
         phase_r <= phase_nxt;
         addr_r  <= addr_nxt;
      end
   end

   logic wr_en;
   logic rd_now;
   assign wr_en  = (phase_r == PH_WRITE);
   assign rd_now = take && !hwrite;

   // -----------------------------------------------------------------
   // Enable registers
   // -----------------------------------------------------------------
   reg8_t framer_irq_enable_r;
   reg8_t framer_irq_enable_nxt;
   reg8_t link_irq_enable_r;
   reg8_t link_irq_enable_nxt;

   // Bits outside this block's sources are kept but steer nothing, except link enable bit 7, which is forced to zero
   always_comb begin
      framer_irq_enable_nxt = framer_irq_enable_r;
      link_irq_enable_nxt   = link_irq_enable_r;
      if (wr_en) begin
         if (is_reg(addr_r, `FRAMER_IRQ_ENABLE_ADDR)) begin
            framer_irq_enable_nxt = hwdata[7:0];
         end else if (is_reg(addr_r, `LINK_IRQ_ENABLE_ADDR)) begin
            link_irq_enable_nxt = {1'b0, hwdata[6:0]};   // Bit 7 reserved
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         framer_irq_enable_r <= `REG_RESET;
         link_irq_enable_r   <= `REG_RESET;
      end else begin
         framer_irq_enable_r <= framer_irq_enable_nxt;
         link_irq_enable_r   <= link_irq_enable_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Clear strobes: read-to-clear, plus write-one-to-clear
   // -----------------------------------------------------------------
   // Clear is taken at the address phase of the read so the data phase
   // returns the value that was sampled before clearing.
   logic rd_link;
   logic rd_framer;
   logic wr_link;
   logic wr_framer;
   assign rd_link   = rd_now && is_reg(haddr[`ADDR_W-1:0], `LINK_STATUS_ONE_ADDR);
   assign rd_framer = rd_now && is_reg(haddr[`ADDR_W-1:0], `FRAMER_STATUS_ADDR);
   assign wr_link   = wr_en && is_reg(addr_r, `LINK_STATUS_ONE_ADDR);
   assign wr_framer = wr_en && is_reg(addr_r, `FRAMER_STATUS_ADDR);

   // -----------------------------------------------------------------
   // Sticky event flags
   // -----------------------------------------------------------------
   logic [4:0] ev_set;
   logic [4:0] ev_clr;
   logic [4:0] ev_flag;

   // Framing bit error sets its flag regardless of out_of_frame
   assign ev_set = {events.crc_error,
                    events.framing_bit_error,
                    events.tx_link_start,
                    events.rx_link_start,
                    events.tx_link_end};
   assign ev_clr = {
      rd_framer || (wr_framer && hwdata[`CRC_BIT]),
      rd_framer || (wr_framer && hwdata[`FE_BIT]),
      rd_link   || (wr_link && hwdata[`TX_START_BIT]),
      rd_link   || (wr_link && hwdata[`RX_START_BIT]),
      rd_link   || (wr_link && hwdata[`TX_END_BIT])};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_flag
         sticky_flag u_flag (
            .hclk    (hclk),
            .hresetn (hresetn),
            .set     (ev_set[gi]),
            .clear   (ev_clr[gi]),
            .flag    (ev_flag[gi])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Message kind, held until the next message
   // -----------------------------------------------------------------
   logic msg_kind_r;
   logic msg_kind_nxt;

   always_comb begin
      msg_kind_nxt = msg_kind_r;
      if (rx_message_valid) begin
         msg_kind_nxt = rx_message_kind;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         msg_kind_r <= 1'b0;
      end else begin
         msg_kind_r <= msg_kind_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Status images and read data
   // -----------------------------------------------------------------
   reg8_t framer_status;
   reg8_t link_status_one;
   always_comb begin
      framer_status                 = `REG_RESET;
      framer_status[`CRC_BIT]       = ev_flag[4];
      framer_status[`FE_BIT]        = ev_flag[3];
      link_status_one               = `REG_RESET;
      link_status_one[`MSG_KIND_BIT] = msg_kind_r;
      link_status_one[`TX_START_BIT] = ev_flag[2];
      link_status_one[`RX_START_BIT] = ev_flag[1];
      link_status_one[`TX_END_BIT]   = ev_flag[0];
   end

   logic [31:0] hrdata_nxt;

   // Read data sampled at address phase, before the clear takes effect
   always_comb begin
      hrdata_nxt = '0;
      if (rd_now) begin
         if (is_reg(haddr[`ADDR_W-1:0], `FRAMER_IRQ_ENABLE_ADDR)) begin
            hrdata_nxt = {24'h000000, framer_irq_enable_r};
         end else if (is_reg(haddr[`ADDR_W-1:0], `LINK_STATUS_ONE_ADDR)) begin
            hrdata_nxt = {24'h000000, link_status_one};
         end else if (is_reg(haddr[`ADDR_W-1:0], `LINK_IRQ_ENABLE_ADDR)) begin
            hrdata_nxt = {24'h000000, link_irq_enable_r};
         end else if (is_reg(haddr[`ADDR_W-1:0], `FRAMER_STATUS_ADDR)) begin
            hrdata_nxt = {24'h000000, framer_status};
         end
      end
   end

   // -----------------------------------------------------------------
   // Interrupt request
   // -----------------------------------------------------------------
   logic irq_nxt;
   // OR of each sticky flag gated by its enable; held until cleared
   always_comb begin
      irq_nxt = (ev_flag[4] && framer_irq_enable_r[`CRC_BIT])
             || (ev_flag[3] && framer_irq_enable_r[`FE_BIT])
             || (ev_flag[2] && link_irq_enable_r[`TX_START_BIT])
             || (ev_flag[1] && link_irq_enable_r[`RX_START_BIT])
             || (ev_flag[0] && link_irq_enable_r[`TX_END_BIT]);
   end

   // Outputs registered; slave never stalls and always answers OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         irq       <= 1'b0;
      end else begin
         hrdata    <= hrdata_nxt;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         irq       <= irq_nxt;
      end
   end

endmodule

//--- link_irq_defines.svh
// Register offsets, field positions and reset values of the link interrupt block
`ifndef LINK_IRQ_DEFINES_SVH
`define LINK_IRQ_DEFINES_SVH

// -----------------------------------------------------------------
// Register byte addresses (index times four)
// -----------------------------------------------------------------
`define FRAMER_IRQ_ENABLE_IDX   12'hb05
`define LINK_STATUS_ONE_IDX     12'hb06
`define LINK_IRQ_ENABLE_IDX     12'hb07
`define FRAMER_STATUS_IDX       12'hb04
`define ADDR_W                  14
`define FRAMER_IRQ_ENABLE_ADDR  14'(`FRAMER_IRQ_ENABLE_IDX * 4)
`define LINK_STATUS_ONE_ADDR    14'(`LINK_STATUS_ONE_IDX * 4)
`define LINK_IRQ_ENABLE_ADDR    14'(`LINK_IRQ_ENABLE_IDX * 4)
`define FRAMER_STATUS_ADDR      14'(`FRAMER_STATUS_IDX * 4)

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define FE_BIT                  0
`define CRC_BIT                 1
`define MSG_KIND_BIT            7
`define TX_START_BIT            6
`define RX_START_BIT            5
`define TX_END_BIT              4

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define REG_RESET               8'h00

`endif

//--- link_irq_pkg.sv
// Types shared by the link interrupt block
package link_irq_pkg;

   // Event strobes coming from the framer and the link controllers
   typedef struct packed {
      logic crc_error;
      logic framing_bit_error;
      logic tx_link_start;
      logic rx_link_start;
      logic tx_link_end;
   } link_events_s;

   // Bus data phase states
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_WRITE,
      PH_READ
   } bus_phase_e;

   typedef logic [7:0] reg8_t;

endpackage

//--- sticky_flag.sv
// One sticky event flag with set-over-clear priority
`timescale 1ns/100ps
module sticky_flag (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic set,
   input  wire logic clear,
   output logic      flag
);

   logic flag_nxt;

   // A set in the clearing cycle wins so no event is lost
   always_comb begin
      flag_nxt = flag;
      if (clear) begin
         flag_nxt = 1'b0;
      end
      if (set) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag <= 1'b0;
      end else begin
         flag <= flag_nxt;
      end
   end

endmodule

//--- t1_framer_link_irq_props.sv
// Port-level checks of the link interrupt block
`timescale 1ns/100ps
`include "link_irq_defines.svh"
module t1_framer_link_irq_props
   import link_irq_pkg::*;
(
   input wire logic         hclk,
   input wire logic         hresetn,
   input wire logic         hsel,
   input wire logic [31:0]  haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic         hready,
   input wire logic [31:0]  hrdata,
   input wire link_events_s events,
   input wire logic         rx_message_kind,
   input wire logic         rx_message_valid,
   input wire logic         irq
);
   // Taken address phases; reads of the link status word
   wire logic take  = hsel & hready & htrans[1];
   wire logic rtake = take & ~hwrite;
   wire logic wtake = take & hwrite;
   wire logic rd1   = rtake & (haddr[13:0] == `LINK_STATUS_ONE_ADDR);
   wire logic anyev = |events;
   wire logic lev   = events.tx_link_start | events.rx_link_start | events.tx_link_end;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Event pulse, then a status read in the next cycle
   sequence s_ev_rd(ev);
      ev ##1 rd1;
   endsequence

   a_rdata_idle: assert property (hrdata != 32'h0 |-> $past(rtake))
      else $error("read data outside a read");
   a_irq_rise: assert property ($rose(irq) |-> $past(anyev, 2) || $past(wtake, 3))
      else $error("irq rose without cause");
   a_irq_fall: assert property ($fell(irq) |-> $past(take, 2) || $past(wtake, 3))
      else $error("irq fell without clear");
   a_tx_start_seen: assert property (s_ev_rd(events.tx_link_start) |=> hrdata[6])
      else $error("tx start flag missing");
   a_rx_start_seen: assert property (s_ev_rd(events.rx_link_start) |=> hrdata[5])
      else $error("rx start flag missing");
   a_tx_end_seen: assert property (s_ev_rd(events.tx_link_end) |=> hrdata[4])
      else $error("tx end flag missing");
   a_read_clears: assert property ((rd1 & ~lev) ##1 ~lev ##1 rd1 |=> hrdata[6:4] == 3'h0)
      else $error("flags survived a read");
   a_kind_seen: assert property (s_ev_rd(rx_message_valid) |=> hrdata[7] == $past(rx_message_kind, 2))
      else $error("message kind wrong");
endmodule

bind t1_framer_link_irq_regs t1_framer_link_irq_props chk (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
   .events, .rx_message_kind, .rx_message_valid, .irq
);

//--- t1_framer_link_irq_regs_tb.sv
// Self-checking bench of the link interrupt block
`timescale 1ns/100ps
`include "link_irq_defines.svh"
module t1_framer_link_irq_regs_tb
   import link_irq_pkg::*;
;
   localparam logic [13:0] A_FE = `FRAMER_IRQ_ENABLE_ADDR;
   localparam logic [13:0] A_LS = `LINK_STATUS_ONE_ADDR;
   localparam logic [13:0] A_LE = `LINK_IRQ_ENABLE_ADDR;
   localparam logic [13:0] A_FS = `FRAMER_STATUS_ADDR;
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, oof, kind, kvalid;
   logic [1:0]   htrans;
   logic [31:0]  haddr, hwdata, hrdata, rd;
   link_events_s ev;
   int           n_mismatch, checked;
   // Rows: address written with all ones, value read back
   logic [13:0]  r_a [4] = '{A_FE, A_LE, 14'h2c00, A_LS};
   logic [31:0]  r_e [4] = '{32'hff, 32'h7f, 32'h0, 32'h0};
   // One event each, where it shows and which bit
   link_events_s e_v [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
   logic [13:0]  e_a [5] = '{A_FS, A_FS, A_LS, A_LS, A_LS};
   logic [31:0]  e_e [5] = '{32'h2, 32'h1, 32'h40, 32'h20, 32'h10};

   t1_framer_link_irq_regs dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .events(ev), .out_of_frame(oof),
      .rx_message_kind(kind), .rx_message_valid(kvalid), .irq(irq)
   );

   always #5 hclk = ~hclk;

   // ----
   // Tasks; each starts and ends just after a rising edge
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      end
   endtask

   // Single word transfer; waits on hready, no fixed latency assumed
   task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {18'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic pulse(input link_events_s e);
      ev <= e;
      @(posedge hclk);
      ev <= '0;
   endtask

   task automatic end_of_test();
      if (n_mismatch == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----
   // Main sequence
   // ----
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, oof, kind, kvalid} = 5'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      ev = '0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, A_FS, 32'h0);
      chk(rd, 32'h0);
      foreach (r_a[i]) begin
         bus(1'b0, r_a[i], 32'h0);
         chk(rd, 32'h0);
         bus(1'b1, r_a[i], 32'hffff_ffff);
         bus(1'b0, r_a[i], 32'h0);
         chk(rd, r_e[i]);
      end
      // Enabled: each event raises irq until its status is read
      foreach (e_v[i]) begin
         chk(irq, 32'h0);
         pulse(e_v[i]);
         repeat (2) @(posedge hclk);
         chk(irq, 32'h1);
         bus(1'b0, e_a[i], 32'h0);
         chk(rd, e_e[i]);
         @(posedge hclk);
         chk(irq, 32'h0);
      end
      // Masked: flags still latch, irq is low once they are read back, out-of-frame has no say
      bus(1'b1, A_FE, 32'h0);
      bus(1'b1, A_LE, 32'h0);
      oof <= 1'b1;
      kind <= 1'b1;
      kvalid <= 1'b1;
      pulse(5'h1f);
      kvalid <= 1'b0;
      bus(1'b0, A_LS, 32'h0);
      chk(rd, 32'hf0);
      bus(1'b0, A_LS, 32'h0);
      chk(rd, 32'h80);
      bus(1'b0, A_FS, 32'h0);
      chk(rd, 32'h3);
      bus(1'b0, A_FS, 32'h0);
      chk(rd, 32'h0);
      chk(irq, 32'h0);
      // Event landing on the clearing read must survive it
      fork
         pulse(5'h01);
         bus(1'b0, A_LS, 32'h0);
      join
      chk(rd, 32'h80);
      bus(1'b0, A_LS, 32'h0);
      chk(rd, 32'h90);
      kind <= 1'b0;
      kvalid <= 1'b1;
      @(posedge hclk);
      kvalid <= 1'b0;
      bus(1'b0, A_LS, 32'h0);
      chk(rd, 32'h0);
      // Reset in mid-run drops a pending request and the enables
      bus(1'b1, A_LE, 32'h10);
      pulse(5'h01);
      repeat (2) @(posedge hclk);
      chk(irq, 32'h1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(irq, 32'h0);
      hresetn <= 1'b1;
      bus(1'b0, A_LE, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, A_LS, 32'h0);
      chk(rd, 32'h0);
      end_of_test();
   end

   // Hang guard, far beyond the roughly 90 cycles needed
   initial begin
      repeat (3000) @(posedge hclk);
      n_mismatch++;
      end_of_test();
   end
endmodule
